/* File: shared/spi_port_pkg.sv */
package spi_port_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL0_OFS = 8'h00;
   localparam logic [7:0] CTRL1_OFS = 8'h04;
   localparam logic [7:0] DATA_OFS = 8'h08;
   // Port control 0 fields
   localparam int EN_BIT = 4;
   localparam int MODE_LSB = 5;
   localparam int MODE_SLV_BIT = 2;
   // Port control 1 fields
   localparam int TRF_BIT = 0;
   localparam int WCOL_BIT = 1;
   localparam int CSEN_BIT = 2;
   localparam int MLS_BIT = 3;
   localparam int POL_BIT = 4;
   localparam int EDGE_BIT = 5;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // Half serial clock periods in system clocks, per clock source
   localparam logic [8:0] HALF0 = 9'h008;
   localparam logic [8:0] HALF1 = 9'h020;
   localparam logic [8:0] HALF2 = 9'h080;
   localparam logic [8:0] HALF3 = 9'h100;
   localparam logic [3:0] BITS = 4'h8;
   localparam logic [4:0] EDGES = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      X_IDLE = 2'b00,
      X_MRUN = 2'b01,
      X_SRUN = 2'b10
   } xfer_t;
endpackage : spi_port_pkg

/* File: rtl/spi_master_slave_port.sv */
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module spi_master_slave_port (
   // System
   input wire logic clock,
   input wire logic reset_n,
   // AXI4-Lite write
   input wire logic awvalid,
   output logic awready,
   input wire logic [spi_port_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [spi_port_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Serial link, output enables low to drive
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_n,
   input wire logic slave_select_n_in,
   output logic slave_select_n_out,
   output logic slave_select_n_oe_n,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_oe_n
);
   import spi_port_pkg::*;

   typedef struct packed {
      logic aw_v;
      logic [ADDR_W-1:0] aw_a;
      logic w_v;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic b_v;
      logic [1:0] b_r;
      logic r_v;
      logic [31:0] r_d;
      logic [1:0] r_r;
      logic [2:0] mode;
      logic en;
      logic edg;
      logic pol;
      logic mls;
      logic csen;
      logic wcol;
      logic trf;
      logic [7:0] tx;
      logic [7:0] rd;
      logic [7:0] sh;
      xfer_t st;
      logic [8:0] div;
      logic [4:0] ecnt;
      logic [3:0] scnt;
      logic [3:0] ccnt;
      logic sck;
      logic sdo;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] lvl;
      logic [2:0] plvl;
   } state_t;

   state_t q;
   state_t n;
   logic master, cpol, cpha, sel, busy, wr_ev, wd_ev, start, fin;
   logic sedge, tick, lead, ev, smp, chg;
   logic [8:0] hc;
   logic [7:0] wd;

   // Bit at shift position i in the chosen order; past the word reads 1
   function automatic logic bit_at(input logic [7:0] d, input logic [3:0] i,
                                   input logic msb);
      logic [2:0] k;
      k = msb ? 3'h7 - i[2:0] : i[2:0];
      bit_at = i[3] ? 1'b1 : d[k];
   endfunction : bit_at

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      wr_ev = 1'b0;
      wd_ev = 1'b0;
      start = 1'b0;
      fin = 1'b0;
      wd = q.w_d[7:0];
      master = ~q.mode[MODE_SLV_BIT];
      cpol = ~q.pol;
      cpha = q.edg;
      sel = ~q.csen | ~q.lvl[1];
      busy = q.st != X_IDLE;
      case (q.mode[1:0])
         2'h0: hc = HALF0;
         2'h1: hc = HALF1;
         2'h2: hc = HALF2;
         default: hc = HALF3;
      endcase
      // Pin synchronisers: clock, select, data-in
      n.s1 = {serial_data_in, slave_select_n_in, serial_clock_pin_in};
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
      n.plvl = q.lvl;
      // Bus slave
      awready = ~q.aw_v & ~q.b_v;
      wready = ~q.w_v & ~q.b_v;
      arready = ~q.r_v;
      if (awvalid && awready) begin
         n.aw_v = 1'b1;
         n.aw_a = awaddr;
      end
      if (wvalid && wready) begin
         n.w_v = 1'b1;
         n.w_d = wdata;
         n.w_s = wstrb;
      end
      if (q.b_v && bready) begin
         n.b_v = 1'b0;
      end
      if (q.r_v && rready) begin
         n.r_v = 1'b0;
      end
      if (arvalid && arready) begin
         n.r_v = 1'b1;
         n.r_r = RESP_OKAY;
         case (araddr)
            CTRL0_OFS: n.r_d = {24'h0, q.mode, q.en, 4'h0};
            CTRL1_OFS: n.r_d = {26'h0, q.edg, q.pol, q.mls, q.csen, q.wcol, q.trf};
            DATA_OFS: n.r_d = {24'h0, q.rd};
            default: begin
               n.r_d = 32'h0;
               n.r_r = RESP_SLVERR;
            end
         endcase
      end
      if (q.aw_v && q.w_v && !q.b_v) begin
         wr_ev = 1'b1;
         n.aw_v = 1'b0;
         n.w_v = 1'b0;
         n.b_v = 1'b1;
         n.b_r = RESP_OKAY;
         case (q.aw_a)
            CTRL0_OFS: begin
               if (q.w_s[0]) begin
                  n.mode = wd[MODE_LSB+:3];
                  n.en = wd[EN_BIT];
               end
            end
            CTRL1_OFS: begin
               if (q.w_s[0]) begin
                  n.edg = wd[EDGE_BIT];
                  n.pol = wd[POL_BIT];
                  n.mls = wd[MLS_BIT];
                  n.csen = wd[CSEN_BIT];
                  n.wcol = q.wcol & wd[WCOL_BIT];
                  n.trf = q.trf & wd[TRF_BIT];
               end
            end
            DATA_OFS: wd_ev = q.w_s[0];
            default: n.b_r = RESP_SLVERR;
         endcase
      end
      if (wd_ev) begin
         if (busy) begin
            n.wcol = 1'b1;
         end else begin
            n.tx = wd;
            start = q.en & master;
         end
      end
      // Shift engine; runs on the system clock, and with en clear it is held in X_IDLE
      sedge = q.en & ~master & sel & (q.lvl[0] ^ q.plvl[0]);
      tick = (q.st == X_MRUN) && (q.div == 9'h0);
      lead = tick ? (q.sck == cpol) : (q.lvl[0] != cpol);
      ev = tick | sedge;
      smp = ev & (lead ^ cpha);
      chg = ev & ~(lead ^ cpha);
      if (q.st == X_MRUN) begin
         if (tick) begin
            n.sck = ~q.sck;
            n.div = hc - 9'h1;
            n.ecnt = q.ecnt + 5'h1;
         end else begin
            n.div = q.div - 9'h1;
         end
      end else if (sedge && lead) begin
         // Only a leading edge opens a word; a stray trailing edge stays idle
         n.st = X_SRUN;
      end
      if (smp) begin
         n.sh = q.mls ? {q.sh[6:0], q.lvl[2]} : {q.lvl[2], q.sh[7:1]};
         n.scnt = q.scnt + 4'h1;
         fin = q.scnt == BITS - 4'h1;
      end
      if (chg) begin
         n.sdo = bit_at(q.tx, cpha ? q.ccnt : q.ccnt + 4'h1, q.mls);
         n.ccnt = q.ccnt + 4'h1;
      end
      if (fin) begin
         n.rd = n.sh;
         n.trf = 1'b1;
         n.scnt = 4'h0;
         n.ccnt = 4'h0;
         if (!master) begin
            n.st = X_IDLE;
         end
      end
      if (tick && q.ecnt == EDGES - 5'h1) begin
         n.st = X_IDLE;
         n.sdo = 1'b1;
      end
      if (q.st == X_IDLE && !(sedge && lead)) begin
         n.scnt = 4'h0;
         n.ccnt = 4'h0;
         n.sck = cpol;
         n.sdo = (~master & sel & ~cpha) ? bit_at(q.tx, 4'h0, q.mls) : 1'b1;
      end
      if (q.st == X_SRUN && (!sel || master)) begin
         n.st = X_IDLE;
      end
      if (!q.en) begin
         n.st = X_IDLE;
         n.sdo = 1'b1;
      end
      if (start) begin
         n.st = X_MRUN;
         n.div = hc - 9'h1;
         n.ecnt = 5'h0;
         n.scnt = 4'h0;
         n.ccnt = 4'h0;
         n.sck = cpol;
         n.sdo = cpha ? 1'b1 : bit_at(wd, 4'h0, q.mls);
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.st <= X_IDLE;
         q.mode <= CTRL0_RST[MODE_LSB+:3];
         q.en <= CTRL0_RST[EN_BIT];
         q.edg <= CTRL1_RST[EDGE_BIT];
         q.pol <= CTRL1_RST[POL_BIT];
         q.mls <= CTRL1_RST[MLS_BIT];
         q.csen <= CTRL1_RST[CSEN_BIT];
         q.rd <= DATA_RST;
         q.tx <= DATA_RST;
         q.sdo <= 1'b1;
         q.sck <= 1'b1;
         q.s1 <= 3'h7;
         q.s2 <= 3'h7;
         q.s3 <= 3'h7;
         q.lvl <= 3'h7;
         q.plvl <= 3'h7;
      end else begin
         q <= n;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign bvalid = q.b_v;
   assign bresp = q.b_r;
   assign rvalid = q.r_v;
   assign rdata = q.r_d;
   assign rresp = q.r_r;
   assign serial_clock_pin_out = q.sck;
   assign serial_clock_pin_oe_n = ~(q.en & master);
   assign slave_select_n_out = q.st != X_MRUN;
   assign slave_select_n_oe_n = ~(q.en & master & q.csen);
   assign serial_data_out = q.sdo;
   assign serial_data_out_oe_n = ~q.en;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   a_sck_idle_lvl: assert property ((q.en && master && q.st == X_IDLE && !start)
      |=> serial_clock_pin_out == $past(cpol)) else $error("clock not at idle level");
   a_pins_released: assert property (!q.en |-> serial_clock_pin_oe_n
      && slave_select_n_oe_n && serial_data_out_oe_n) else $error("pin driven while off");
   a_slave_clk_float: assert property ((q.en && !master) |-> serial_clock_pin_oe_n)
      else $error("slave drives clock");
   a_sdo_idle_high: assert property ((q.en && master && q.st == X_IDLE) |-> serial_data_out)
      else $error("data out not high at idle");
   a_master_start: assert property (start |=> (q.st == X_MRUN && !slave_select_n_out)[*8])
      else $error("write did not start transfer");
   a_select_first: assert property ($fell(slave_select_n_out) |=> $stable(serial_clock_pin_out)[*6])
      else $error("clock edge too soon after select");
   a_collision_set: assert property ((wd_ev && busy) |=> q.wcol && $stable(q.tx))
      else $error("collision not flagged");
   a_done_set: assert property (fin |=> q.trf) else $error("done flag not set");
   a_done_held: assert property ((q.trf && !(wr_ev && q.aw_a == CTRL1_OFS)) |=> q.trf)
      else $error("done flag lost");
   a_rx_latched: assert property (!$stable(q.rd) |-> $past(fin))
      else $error("data register changed mid word");

   c_master_xfer: cover property (fin && master);
   c_slave_xfer: cover property (fin && !master);
   c_collision: cover property (wd_ev && busy);
endmodule : spi_master_slave_port

/* File: bench/spi_far_device.sv */
`timescale 1ns/100ps
module spi_far_device (
   // Line levels
   input wire logic sck,
   input wire logic ss_n,
   input wire logic sdo,
   output logic sdi,
   // Own clock and select
   output logic m_sck,
   output logic m_ss_n,
   // Settings
   input wire logic lead,
   input wire logic pol,
   input wire logic msb,
   input wire logic edg
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   initial begin
      sdi = 1'b0;
      m_sck = 1'b0;
      m_ss_n = 1'b1;
      tx_q = 8'h00;
      rx_q = 8'h00;
   end
   // Slave role: first bit on select, sample lead edge, shift trail edge
   always @(ss_n) begin
      if (!lead) sdi = ss_n ? ~sdi : (msb ? tx_q[7] : tx_q[0]);
   end
   always @(sck) begin
      if (!lead && !ss_n && sck == pol) begin
         rx_q = msb ? {rx_q[6:0], sdo} : {sdo, rx_q[7:1]};
      end else if (!lead && !ss_n) begin
         tx_q = msb ? {tx_q[6:0], 1'b0} : {1'b0, tx_q[7:1]};
         sdi = msb ? tx_q[7] : tx_q[0];
      end
   end
   // Master role, clock stands still outside the frame
   task automatic drive(input logic [7:0] v, output logic [7:0] got);
      int k;
      m_ss_n = 1'b0;
      for (int i = 0; i < 8; i++) begin
         k = msb ? 7 - i : i;
         if (!edg) sdi = v[k];
         #80 m_sck = ~m_sck;
         if (edg) sdi = v[k];
         else got[k] = sdo;
         #80 m_sck = ~m_sck;
         if (edg) got[k] = sdo;
      end
      #80 m_ss_n = 1'b1;
      sdi = ~sdi;
   endtask : drive
endmodule : spi_far_device

/* File: bench/spi_master_slave_port_bench.sv */
`timescale 1ns/100ps
module spi_master_slave_port_bench;
   import spi_port_pkg::*;
   logic clock, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sck_o, sck_oe_n, ss_o, ss_oe_n;
   logic sdo, sdo_oe_n, sdi, m_sck, m_ss_n, lead, pol, msb, edg;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, q;
   logic [1:0] bresp, rresp;
   logic [8:0] half [4] = '{HALF0, HALF1, HALF2, HALF3};
   int errors, comparisons, low_cycles;
   wire sck_w = sck_oe_n ? m_sck : sck_o;
   wire ss_w = ss_oe_n ? m_ss_n : ss_o;
   wire sdo_w = sdo_oe_n ? 1'bz : sdo;
   spi_master_slave_port dut_u (.clock(clock), .reset_n(reset_n),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(4'h1), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
      .serial_clock_pin_oe_n(sck_oe_n), .slave_select_n_in(ss_w),
      .slave_select_n_out(ss_o), .slave_select_n_oe_n(ss_oe_n),
      .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe_n(sdo_oe_n));
   spi_far_device far_u (.sck(sck_w), .ss_n(ss_w), .sdo(sdo_w), .sdi(sdi),
      .m_sck(m_sck), .m_ss_n(m_ss_n), .lead(lead), .pol(pol), .msb(msb), .edg(edg));
   always @(posedge clock) if (ss_o === 1'b0) low_cycles++;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // AXI4-Lite access, q is the response code on writes
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, got;
      logic [1:0] r;
      logic [1:0] e;
      @(posedge clock);
      {awaddr, araddr, wdata} <= {a, a, d};
      {awvalid, wvalid, bready, arvalid, rready} <= {we, we, we, !we, !we};
      do begin
         @(negedge clock);
         ta = (awvalid & awready) | (arvalid & arready);
         tw = wvalid & wready;
         got = we ? bvalid : rvalid;
         q = we ? 32'(bresp) : rdata;
         r = we ? bresp : rresp;
         @(posedge clock);
         {awvalid, arvalid} <= {awvalid & ~ta, arvalid & ~ta};
         wvalid <= wvalid & ~tw;
      end while (got !== 1'b1);
      {bready, rready} <= 2'b00;
      e = (a == CTRL0_OFS || a == CTRL1_OFS || a == DATA_OFS) ? RESP_OKAY : RESP_SLVERR;
      chk("bus resp", 32'(e), 32'(r));
   endtask : bus
   task automatic wait_done();
      do begin
         bus(0, CTRL1_OFS, 0);
      end while (q[TRF_BIT] !== 1'b1);
   endtask : wait_done
   task automatic t_reset();
      chk("oe", 3'b111, {sck_oe_n, ss_oe_n, sdo_oe_n});
      bus(0, CTRL0_OFS, 0);
      chk("ctrl0", CTRL0_RST, q);
      bus(0, CTRL1_OFS, 0);
      chk("ctrl1", CTRL1_RST, q);
      bus(1, 8'h0c, 1);
      chk("unmapped resp", RESP_SLVERR, q);
      bus(0, 8'h0c, 0);
      chk("unmapped read", 0, q);
   endtask : t_reset
   task automatic t_master();
      logic [31:0] c1;
      for (int i = 0; i < 4; i++) begin
         {lead, pol, msb} = {1'b0, i[0], i[1]};
         c1 = (32'(i[0]) << POL_BIT) | (32'(i[1]) << MLS_BIT) | 32'h4;
         bus(1, CTRL0_OFS, i << MODE_LSB);
         bus(1, CTRL1_OFS, c1);
         bus(1, CTRL0_OFS, (i << MODE_LSB) | (1 << EN_BIT));
         chk("idle pins", {!i[0], 4'hc}, {sck_o, ss_o, sdo, sck_oe_n, ss_oe_n});
         far_u.tx_q = 8'hc3 ^ i;
         low_cycles = 0;
         bus(1, DATA_OFS, 8'h5a + i);
         bus(1, DATA_OFS, 8'hff);
         wait_done();
         while (ss_o === 1'b0) @(posedge clock);
         chk("far rx", 8'h5a + i, far_u.rx_q);
         chk("select low", {half[i], 4'h0}, low_cycles);
         bus(0, DATA_OFS, 0);
         chk("data", 8'hc3 ^ i, q);
         bus(0, CTRL1_OFS, 0);
         chk("flags", c1 | 3, q);
         bus(1, CTRL1_OFS, c1);
         bus(0, CTRL1_OFS, 0);
         chk("flags cleared", c1, q);
      end
   endtask : t_master
   task automatic t_slave();
      logic [7:0] got;
      for (int e = 0; e < 2; e++) begin
         {lead, pol, msb, edg} = {3'b111, e[0]};
         bus(1, CTRL0_OFS, 32'h80);
         bus(1, CTRL1_OFS, 32'h1c | (e << EDGE_BIT));
         bus(1, CTRL0_OFS, 32'h90);
         chk("slave oe", 3'b110, {sck_oe_n, ss_oe_n, sdo_oe_n});
         bus(1, DATA_OFS, 32'h96 ^ e);
         far_u.drive(8'h3c ^ e, got);
         chk("slave out", 8'h96 ^ e, got);
         wait_done();
         bus(0, DATA_OFS, 0);
         chk("slave data", 8'h3c ^ e, q);
      end
   endtask : t_slave
   task automatic t_off();
      bus(1, CTRL0_OFS, 0);
      chk("off oe", 3'b111, {sck_oe_n, ss_oe_n, sdo_oe_n});
      bus(1, CTRL1_OFS, 32'h10);
      bus(1, CTRL0_OFS, 32'h10);
      chk("no select", 3'b010, {sck_oe_n, ss_oe_n, sdo_oe_n});
   endtask : t_off
   task automatic stop_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #200000;
      errors++;
      stop_test();
   end
   initial begin
      {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, lead, pol, msb, edg} = '0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      t_reset();
      t_master();
      t_slave();
      t_off();
      stop_test();
   end
endmodule : spi_master_slave_port_bench
